// ===== abp_map.svh
// offsets, field positions, reset values and timing figures of the apd bias block
`ifndef ABP_MAP_SVH
`define ABP_MAP_SVH

// ----------------------------------------------------------------
// clock and switching rates (rates in Hz)
// ----------------------------------------------------------------
`define ABP_CLK_HZ 100000000
`define ABP_FSW_HZ_0 131250
`define ABP_FSW_HZ_1 262500
`define ABP_FSW_HZ_2 525000
`define ABP_FSW_HZ_3 1050000
`define ABP_DUTY_LIMIT_PCT 90
`define ABP_DUTY_FULL 255

// ----------------------------------------------------------------
// register offsets and tables
// ----------------------------------------------------------------
`define ABP_UPPER_BASE 8'h80
`define ABP_TABLE_CFG 8'h02
`define ABP_TABLE_LUT 8'h07
`define ABP_ADDR_STATUS 8'h6e
`define ABP_ADDR_DRIVE 8'h78
`define ABP_ADDR_LEVEL 8'h79
`define ABP_ADDR_SW_CFG 8'h88
`define ABP_ADDR_OUT_DEF 8'hc0
`define ABP_ADDR_TRIP 8'hc3
`define ABP_ADDR_SETPOINT 8'hfe

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define ABP_CFG_AUTO_BIT 0
`define ABP_CFG_INV_BIT 1
`define ABP_CFG_SRC_BIT 2
`define ABP_CFG_QT_BIT 3
`define ABP_CFG_RATE_LSB 4
`define ABP_STAT_NRDY_BIT 0
`define ABP_STAT_LOSS_BIT 1
`define ABP_STAT_TRIP_BIT 2

// ----------------------------------------------------------------
// reset values (sram is all low until recall)
// ----------------------------------------------------------------
`define ABP_BYTE_RESET 8'h00

`endif

// ===== abp_pkg.sv
// types shared by the apd bias pwm and digital pin block
package abp_pkg;

  // ----------------------------------------------------------------
  // power sequencing
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ABP_PWR_OFF    = 2'b00,
    ABP_PWR_RECALL = 2'b01,
    ABP_PWR_RUN    = 2'b10
  } abp_pwr_type;

  // ----------------------------------------------------------------
  // register access and nonvolatile image
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic [7:0] table_sel;
    logic [7:0] addr;
    logic [7:0] wdata;
  } abp_reg_req_type;

  typedef struct packed {
    logic [7:0] output_default;
    logic [7:0] sw_config;
    logic [7:0] trip_level;
  } abp_nv_image_type;

endpackage

// ===== abp_od_pins.sv
// open-drain pin cells with registered enables and sampled levels
`timescale 1ns/1ns
module abp_od_pins #(
  parameter int N = 4
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [N-1:0] release_req,
  input wire logic [N-1:0] pin_in,
  output logic [N-1:0] pin_level,
  output logic [N-1:0] pin_out,
  output logic [N-1:0] pin_oe_n
);

  logic [N-1:0] next_oe_n;
  logic [N-1:0] next_level;

  if (N < 1) begin : g_chk
    $error("abp_od_pins needs at least one pin");
  end

  // open drain: the pad only ever pulls low
  assign pin_out = '0;

  always_comb begin
    next_oe_n = release_req;
    next_level = pin_in;
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_oe_n <= '1;
      pin_level <= '0;
    end else begin
      pin_oe_n <= next_oe_n;
      pin_level <= next_level;
    end
  end

endmodule

// ===== abp_pwm_core.sv
// pwm pulse train with rate select, duty limit and blanking
`timescale 1ns/1ns
`include "abp_map.svh"
module abp_pwm_core import abp_pkg::*; #(
  parameter int CLK_HZ = `ABP_CLK_HZ
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [1:0] rate_sel,
  input wire logic [7:0] duty_cmd,
  input wire logic block,
  output logic gate,
  output logic period_start
);

  if (CLK_HZ / `ABP_FSW_HZ_0 > 1023 || CLK_HZ / `ABP_FSW_HZ_3 < 10) begin : g_chk
    $error("abp_pwm_core clock rate out of range");
  end

  function automatic logic [9:0] period_cycles(input logic [1:0] r);
    unique case (r)
      2'b00: period_cycles = 10'(CLK_HZ / `ABP_FSW_HZ_0);
      2'b01: period_cycles = 10'(CLK_HZ / `ABP_FSW_HZ_1);
      2'b10: period_cycles = 10'(CLK_HZ / `ABP_FSW_HZ_2);
      2'b11: period_cycles = 10'(CLK_HZ / `ABP_FSW_HZ_3);
    endcase
  endfunction

  function automatic logic [9:0] limit_cycles(input logic [1:0] r);
    limit_cycles = 10'((20'(period_cycles(r)) * 20'(`ABP_DUTY_LIMIT_PCT)) / 20'd100);
  endfunction

  // ----------------------------------------------------------------
  // high time per period
  // ----------------------------------------------------------------
  function automatic logic [9:0] high_cycles(input logic [1:0] r, input logic [7:0] c);
    logic [19:0] raw;
    raw = (20'(period_cycles(r)) * 20'(c)) / 20'(`ABP_DUTY_FULL);
    high_cycles = (raw > 20'(limit_cycles(r))) ? limit_cycles(r) : raw[9:0];
  endfunction

  logic [9:0] cnt;
  logic [9:0] next_cnt;
  logic [1:0] rate_q;
  logic [1:0] next_rate;
  logic [9:0] high_len;
  logic [9:0] next_high;
  logic next_gate;
  logic next_start;

  always_comb begin
    next_cnt = cnt + 10'd1;
    next_rate = rate_q;
    next_high = high_len;
    next_start = 1'b0;
    if (cnt >= period_cycles(rate_q) - 10'd1) begin
      next_cnt = '0;
      next_rate = rate_sel;
      next_high = high_cycles(rate_sel, duty_cmd);
      next_start = 1'b1;
    end
    // pulse high while count below high time, blanked by block
    next_gate = !block && (next_cnt < next_high);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
      rate_q <= 2'b00;
      high_len <= '0;
      gate <= 1'b0;
      period_start <= 1'b0;
    end else begin
      cnt <= next_cnt;
      rate_q <= next_rate;
      high_len <= next_high;
      gate <= next_gate;
      period_start <= next_start;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_duty_limit: assert property (
    @(posedge clk_sys) disable iff (!rst_n) gate |-> cnt < limit_cycles(rate_q))
    else $error("gate high beyond ninety percent of period");

  a_period_length: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    period_start && $past(rst_n) |-> $past(cnt) == period_cycles($past(rate_q)) - 10'd1)
    else $error("switching period has wrong length");

  a_zero_duty: assert property (
    @(posedge clk_sys) disable iff (!rst_n) high_len == 10'd0 |-> !gate)
    else $error("gate high with zero duty");

endmodule

// ===== abp_bias_pwm_io.sv
// apd bias pwm control, setpoint table and open-drain digital pins
// ----------------------------------------------------------------
// ----------------------------------------------------------------
`timescale 1ns/1ns
`include "abp_map.svh"
module abp_bias_pwm_io import abp_pkg::*; #(
  parameter int LUT_DEPTH = 32,
  parameter int CLK_HZ = `ABP_CLK_HZ
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic supply_ok,
  input wire logic recall_done,
  input wire abp_nv_image_type nv_image,
  input wire abp_reg_req_type reg_req,
  input wire logic pw2_granted,
  output logic [7:0] reg_rdata,
  output logic nv_default_wr,
  input wire logic [$clog2(LUT_DEPTH)-1:0] temp_index,
  input wire logic [7:0] loop_duty_cmd,
  input wire logic [7:0] apd_current_monitor_input,
  input wire logic loss_of_signal_input,
  input wire logic [3:0] io_pin_in,
  output logic [3:0] io_pin_out,
  output logic [3:0] io_pin_oe_n,
  output logic gate_drive_pin,
  output logic [7:0] bias_setpoint_value,
  output logic apd_overcurrent_trip
);

  localparam int IDX_W = $clog2(LUT_DEPTH);

  // a depth that is not a power of two would let temp_index read past the table
  if (LUT_DEPTH < 2 || LUT_DEPTH > 128 || (LUT_DEPTH & (LUT_DEPTH - 1)) != 0) begin : g_chk
    $error("table depth must be a power of two between 2 and 128");
  end

  // ----------------------------------------------------------------
  // decode shared by the write and read paths
  // ----------------------------------------------------------------
  // lower memory ignores the table select; upper offsets need it
  function automatic logic reg_hit(input abp_reg_req_type r, input logic [7:0] tbl,
                                   input logic [7:0] a);
    reg_hit = (r.addr == a) && ((a < `ABP_UPPER_BASE) || (r.table_sel == tbl));
  endfunction

  function automatic logic lut_hit(input abp_reg_req_type r);
    lut_hit = (r.table_sel == `ABP_TABLE_LUT) && (r.addr >= `ABP_UPPER_BASE) &&
              (int'(r.addr) < int'(`ABP_UPPER_BASE) + LUT_DEPTH);
  endfunction

  // ----------------------------------------------------------------
  // power sequencing
  // ----------------------------------------------------------------
  abp_pwr_type pwr, next_pwr;
  logic recalled, next_recalled, running, recall_now;

  assign running = (pwr == ABP_PWR_RUN);
  assign recall_now = (pwr == ABP_PWR_RECALL) && recall_done;

  // settings survive a dip below the analog level, so no second recall
  always_comb begin
    next_pwr = pwr;
    next_recalled = recalled;
    unique case (pwr)
      ABP_PWR_OFF: begin
        if (supply_ok) begin
          next_pwr = recalled ? ABP_PWR_RUN : ABP_PWR_RECALL;
        end
      end
      ABP_PWR_RECALL: begin
        if (!supply_ok) begin
          next_pwr = ABP_PWR_OFF;
        end else if (recall_done) begin
          next_pwr = ABP_PWR_RUN;
          next_recalled = 1'b1;
        end
      end
      ABP_PWR_RUN: begin
        if (!supply_ok) begin
          next_pwr = ABP_PWR_OFF;
        end
      end
      default: begin
        next_pwr = ABP_PWR_OFF;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pwr <= ABP_PWR_OFF;
      recalled <= 1'b0;
    end else begin
      pwr <= next_pwr;
      recalled <= next_recalled;
    end
  end

  // ----------------------------------------------------------------
  // temperature table
  // ----------------------------------------------------------------
  logic [7:0] lut_mem [LUT_DEPTH];
  logic [7:0] lut_word;
  logic lut_we;

  assign lut_word = lut_mem[temp_index];
  assign lut_we = reg_req.wr && pw2_granted && lut_hit(reg_req);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LUT_DEPTH; i++) begin
        lut_mem[i] <= `ABP_BYTE_RESET;
      end
    end else if (lut_we) begin
      lut_mem[reg_req.addr[IDX_W-1:0]] <= reg_req.wdata;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] pin_drive_byte, switching_config, output_default_byte, overcurrent_trip_level;
  logic [7:0] next_drive, next_config, next_default, next_trip_level, next_setpoint;
  logic next_nv_wr, auto_update, host_wr_setpoint;

  assign auto_update = switching_config[`ABP_CFG_AUTO_BIT];
  assign host_wr_setpoint = reg_req.wr &&
                            reg_hit(reg_req, `ABP_TABLE_CFG, `ABP_ADDR_SETPOINT);

  // a recall in the same cycle as a host write wins: it reloads drive, default, config and trip; table writes still land
  always_comb begin
    next_drive = pin_drive_byte;
    next_config = switching_config;
    next_default = output_default_byte;
    next_trip_level = overcurrent_trip_level;
    next_setpoint = bias_setpoint_value;
    next_nv_wr = 1'b0;
    if (recall_now) begin
      next_drive = nv_image.output_default;
      next_default = nv_image.output_default;
      next_config = nv_image.sw_config;
      next_trip_level = nv_image.trip_level;
    end else if (reg_req.wr) begin
      if (reg_hit(reg_req, `ABP_TABLE_CFG, `ABP_ADDR_DRIVE)) begin
        next_drive = reg_req.wdata;
      end
      if (reg_hit(reg_req, `ABP_TABLE_CFG, `ABP_ADDR_SW_CFG)) begin
        next_config = reg_req.wdata;
      end
      // default byte needs level two password
      if (reg_hit(reg_req, `ABP_TABLE_CFG, `ABP_ADDR_OUT_DEF) && pw2_granted) begin
        next_default = reg_req.wdata;
        next_nv_wr = 1'b1;
      end
      if (reg_hit(reg_req, `ABP_TABLE_CFG, `ABP_ADDR_TRIP)) begin
        next_trip_level = reg_req.wdata;
      end
      if (host_wr_setpoint) begin
        next_setpoint = reg_req.wdata;
      end
    end
    // table overrides only in auto mode
    if (running && auto_update) begin
      next_setpoint = lut_word;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pin_drive_byte <= `ABP_BYTE_RESET;
      switching_config <= `ABP_BYTE_RESET;
      output_default_byte <= `ABP_BYTE_RESET;
      overcurrent_trip_level <= `ABP_BYTE_RESET;
      bias_setpoint_value <= `ABP_BYTE_RESET;
      nv_default_wr <= 1'b0;
    end else begin
      pin_drive_byte <= next_drive;
      switching_config <= next_config;
      output_default_byte <= next_default;
      overcurrent_trip_level <= next_trip_level;
      bias_setpoint_value <= next_setpoint;
      nv_default_wr <= next_nv_wr;
    end
  end

  // ----------------------------------------------------------------
  // quick trip and pulse generation
  // ----------------------------------------------------------------
  logic next_trip;
  logic pwm_block;

  always_comb begin
    next_trip = running && (apd_current_monitor_input > overcurrent_trip_level);
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      apd_overcurrent_trip <= 1'b0;
    end else begin
      apd_overcurrent_trip <= next_trip;
    end
  end

  // no pulses while tripped or unpowered
  assign pwm_block = apd_overcurrent_trip || !running;

  abp_pwm_core #(
    .CLK_HZ(CLK_HZ)
  ) u_pwm (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .rate_sel(switching_config[`ABP_CFG_RATE_LSB +: 2]),
    .duty_cmd(loop_duty_cmd),
    .block(pwm_block),
    .gate(gate_drive_pin),
    .period_start()
  );

  // ----------------------------------------------------------------
  // digital pins (index 0 is the first pin, 1..3 the general pins)
  // ----------------------------------------------------------------
  logic [3:0] pin_release;
  logic [3:0] pin_level;
  logic first_src_general;
  logic loss_drive;

  assign first_src_general = recalled && switching_config[`ABP_CFG_SRC_BIT];
  assign loss_drive = loss_of_signal_input ^ switching_config[`ABP_CFG_INV_BIT];

  // a released pin floats high through its external pullup
  always_comb begin
    pin_release = 4'hf;
    if (running) begin
      // loss input drives first pin by default
      pin_release[0] = first_src_general ? pin_drive_byte[0] : loss_drive;
      pin_release[3:1] = pin_drive_byte[3:1];
      // trip releases pin two to fire the discharge switch
      if (switching_config[`ABP_CFG_QT_BIT] && apd_overcurrent_trip) begin
        pin_release[2] = 1'b1;
      end
    end
  end

  abp_od_pins #(
    .N(4)
  ) u_pins (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .release_req(pin_release),
    .pin_in(io_pin_in),
    .pin_level(pin_level),
    .pin_out(io_pin_out),
    .pin_oe_n(io_pin_oe_n)
  );

  // ----------------------------------------------------------------
  // read path (unmapped offsets read zero)
  // ----------------------------------------------------------------
  logic [7:0] next_rdata;
  logic [7:0] status_byte;

  always_comb begin
    status_byte = 8'h00;
    status_byte[`ABP_STAT_NRDY_BIT] = !running;
    // loss flag is the first pin level
    status_byte[`ABP_STAT_LOSS_BIT] = pin_level[0];
    status_byte[`ABP_STAT_TRIP_BIT] = apd_overcurrent_trip;
    next_rdata = 8'h00;
    if (reg_hit(reg_req, `ABP_TABLE_CFG, `ABP_ADDR_STATUS)) begin
      next_rdata = status_byte;
    end else if (reg_hit(reg_req, `ABP_TABLE_CFG, `ABP_ADDR_DRIVE)) begin
      next_rdata = pin_drive_byte;
    end else if (reg_hit(reg_req, `ABP_TABLE_CFG, `ABP_ADDR_LEVEL)) begin
      next_rdata = {4'h0, pin_level[3:1], 1'b0};
    end else if (reg_hit(reg_req, `ABP_TABLE_CFG, `ABP_ADDR_SW_CFG)) begin
      next_rdata = switching_config;
    end else if (reg_hit(reg_req, `ABP_TABLE_CFG, `ABP_ADDR_OUT_DEF)) begin
      next_rdata = output_default_byte;
    end else if (reg_hit(reg_req, `ABP_TABLE_CFG, `ABP_ADDR_TRIP)) begin
      next_rdata = overcurrent_trip_level;
    end else if (reg_hit(reg_req, `ABP_TABLE_CFG, `ABP_ADDR_SETPOINT)) begin
      next_rdata = bias_setpoint_value;
    end else if (lut_hit(reg_req)) begin
      next_rdata = lut_mem[reg_req.addr[IDX_W-1:0]];
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  sequence s_recall;
    pwr == ABP_PWR_RECALL && recall_done;
  endsequence

  sequence s_over_level;
    running && (apd_current_monitor_input > overcurrent_trip_level);
  endsequence

  a_trip_blocks_gate: assert property (
    s_over_level |=> apd_overcurrent_trip ##1 !gate_drive_pin)
    else $error("pulse seen after overcurrent trip");
  a_auto_table: assert property (
    running && auto_update |=> bias_setpoint_value == $past(lut_word))
    else $error("setpoint not taken from table");
  a_manual_hold: assert property (
    running && !auto_update && !host_wr_setpoint |=> $stable(bias_setpoint_value))
    else $error("setpoint changed in manual mode");
  a_recall_default: assert property (
    s_recall |=> pin_drive_byte == $past(nv_image.output_default) && running)
    else $error("drive byte not loaded from default");
  a_outputs_released: assert property (
    !running |=> io_pin_oe_n[3:1] == 3'b111)
    else $error("general pin driven before power up");
  a_default_guard: assert property (
    reg_req.wr && !pw2_granted && !recall_now |=> $stable(output_default_byte))
    else $error("default byte written without password");
  a_loss_pin: assert property (
    running && !first_src_general |=> io_pin_oe_n[0] == $past(loss_drive))
    else $error("first pin not following loss input");
  a_loss_status: assert property (
    reg_hit(reg_req, `ABP_TABLE_CFG, `ABP_ADDR_STATUS) |=>
      reg_rdata[`ABP_STAT_LOSS_BIT] == $past(pin_level[0]))
    else $error("status loss flag differs from pin level");
  a_trip_pin_two: assert property (
    running && switching_config[`ABP_CFG_QT_BIT] && apd_overcurrent_trip |=> io_pin_oe_n[2])
    else $error("pin two pulled low during trip");

endmodule

// ===== abp_pin_model.sv
// pull-up network and external drivers standing on the open-drain pins
`timescale 1ns/1ns
module abp_pin_model (
  input wire logic [3:0] io_pin_oe_n,
  input wire logic [3:0] ext_low,
  output logic [3:0] io_pin_in
);
  // ----------------------------------------------------------------
  // wired-and pin level
  // ----------------------------------------------------------------
  // a released pin floats up through its resistor; any party may pull it low
  assign io_pin_in = io_pin_oe_n & ~ext_low;
endmodule

// ===== tb_abp_bias_pwm_io.sv
// self-checking bench for the apd bias pwm and digital pin block
`timescale 1ns/1ns
module tb_abp_bias_pwm_io;
  import abp_pkg::*;
  logic clk_sys, rst_n, supply_ok, recall_done, pw2_granted, loss;
  abp_nv_image_type nv_image;
  abp_reg_req_type reg_req;
  logic [4:0] temp_index;
  logic [7:0] loop_cmd, mon, reg_rdata, setpoint;
  logic [3:0] pin_in, pin_out, oe_n, ext_low;
  logic nv_wr, gate, trip;
  int n_mismatch = 0;
  int cmp_count = 0;
  int nvw_count = 0;

  abp_bias_pwm_io uut (.clk_sys(clk_sys), .rst_n(rst_n), .supply_ok(supply_ok),
    .recall_done(recall_done), .nv_image(nv_image), .reg_req(reg_req),
    .pw2_granted(pw2_granted), .reg_rdata(reg_rdata), .nv_default_wr(nv_wr),
    .temp_index(temp_index), .loop_duty_cmd(loop_cmd), .apd_current_monitor_input(mon),
    .loss_of_signal_input(loss), .io_pin_in(pin_in), .io_pin_out(pin_out),
    .io_pin_oe_n(oe_n), .gate_drive_pin(gate), .bias_setpoint_value(setpoint),
    .apd_overcurrent_trip(trip));
  abp_pin_model pins (.io_pin_oe_n(oe_n), .ext_low(ext_low), .io_pin_in(pin_in));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys) if (nv_wr === 1'b1) nvw_count <= nvw_count + 1;

  task automatic print_verdict;
    if (n_mismatch == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [7:0] t, input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_req = '{1'b1, t, a, d};
    @(negedge clk_sys);
    reg_req.wr = 1'b0;
  endtask

  // read data is registered, so it is looked at one cycle after the address
  task automatic rd(input string nm, input logic [7:0] t, input logic [7:0] a,
                    input logic [7:0] e);
    @(negedge clk_sys);
    reg_req = '{1'b0, t, a, 8'h00};
    @(negedge clk_sys);
    chk(nm, {8'h00, e}, {8'h00, reg_rdata});
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  // skips a partial pulse, then times one whole high phase and period
  task automatic meas(output int hi, output int per);
    int n;
    n = 0;
    while (gate === 1'b1 && n < 2000) begin wait_n(1); n++; end
    while (gate !== 1'b1 && n < 4000) begin wait_n(1); n++; end
    hi = 0;
    while (gate === 1'b1 && hi < 2000) begin wait_n(1); hi++; end
    per = hi;
    while (gate !== 1'b1 && per < 2000) begin wait_n(1); per++; end
  endtask

  task automatic count_high(input int n, output int hi);
    hi = 0;
    repeat (n) begin wait_n(1); if (gate !== 1'b0) hi++; end
  endtask

  initial begin
    #1_000_000;
    n_mismatch++;
    print_verdict();
  end

  initial begin
    int hi, per, e;
    int pt[4];
    logic [7:0] cmds[3];
    pt = '{761, 380, 190, 95};
    cmds = '{8'hff, 8'h80, 8'h00};
    rst_n = 1'b0; supply_ok = 1'b0; recall_done = 1'b0; pw2_granted = 1'b0; loss = 1'b0;
    nv_image = '{8'h0d, 8'h30, 8'h80};
    reg_req = '0; temp_index = 5'd5; loop_cmd = 8'hff; mon = 8'h00; ext_low = 4'h0;
    wait_n(4);
    rst_n = 1'b1;
    // ----------------------------------------------------------------
    // power sequencing and first pin
    // ----------------------------------------------------------------
    wait_n(2);
    chk("oe_n off", 16'h000f, {12'h000, oe_n});
    rd("status off", 8'h00, 8'h6e, 8'h03);
    supply_ok = 1'b1;
    wait_n(2);
    recall_done = 1'b1;
    wait_n(1);
    recall_done = 1'b0;
    wait_n(3);
    chk("oe_n default", 16'h000c, {12'h000, oe_n});
    rd("status loss low", 8'h00, 8'h6e, 8'h00);
    loss = 1'b1;
    wait_n(3);
    rd("status loss high", 8'h00, 8'h6e, 8'h02);
    wr(8'h02, 8'h88, 8'h32);
    wait_n(3);
    rd("status inverted", 8'h00, 8'h6e, 8'h00);
    // ----------------------------------------------------------------
    // general pins, password and refused accesses
    // ----------------------------------------------------------------
    wr(8'h02, 8'h88, 8'h34);
    wr(8'h00, 8'h78, 8'h05);
    loss = 1'b0;
    wait_n(3);
    chk("oe_n drive", 16'h0005, {12'h000, oe_n});
    rd("levels", 8'h00, 8'h79, 8'h04);
    ext_low = 4'b0100;
    wait_n(3);
    rd("levels held", 8'h00, 8'h79, 8'h00);
    ext_low = 4'h0;
    wr(8'h00, 8'h79, 8'hff);
    rd("levels ro", 8'h00, 8'h79, 8'h04);
    rd("unmapped", 8'h00, 8'h10, 8'h00);
    wr(8'h02, 8'hc0, 8'h0f);
    rd("default locked", 8'h02, 8'hc0, 8'h0d);
    chk("nv store none", 16'h0000, nvw_count[15:0]);
    pw2_granted = 1'b1;
    wr(8'h02, 8'hc0, 8'h0f);
    rd("default open", 8'h02, 8'hc0, 8'h0f);
    chk("nv store one", 16'h0001, nvw_count[15:0]);
    // ----------------------------------------------------------------
    // switching rate and duty limit
    // ----------------------------------------------------------------
    for (int r = 0; r < 4; r++) begin
      wr(8'h02, 8'h88, {2'b00, r[1:0], 4'h4});
      foreach (cmds[i]) begin
        loop_cmd = cmds[i];
        wait_n(1600);
        e = pt[r] * cmds[i] / 255;
        if (e > pt[r] * 9 / 10) e = pt[r] * 9 / 10;
        if (cmds[i] == 8'h00) begin
          count_high(1600, hi);
          chk("zero duty", 16'h0000, hi[15:0]);
        end else begin
          meas(hi, per);
          chk("period", pt[r][15:0], per[15:0]);
          chk("high time", e[15:0], hi[15:0]);
        end
      end
    end
    // ----------------------------------------------------------------
    // quick trip
    // ----------------------------------------------------------------
    loop_cmd = 8'hff;
    wr(8'h02, 8'h88, 8'h3c);
    wr(8'h00, 8'h78, 8'h01);
    mon = 8'h80;
    wait_n(200);
    meas(hi, per);
    chk("no trip at level", 16'd85, hi[15:0]);
    mon = 8'h81;
    wait_n(3);
    chk("trip", 16'h0001, {15'h0000, trip});
    chk("pin two trip", 16'h0005, {12'h000, oe_n});
    rd("status trip", 8'h00, 8'h6e, 8'h06);
    count_high(400, hi);
    chk("blocked", 16'h0000, hi[15:0]);
    mon = 8'h00;
    wait_n(3);
    chk("trip cleared", 16'h0001, {12'h000, oe_n});
    // ----------------------------------------------------------------
    // supply dip keeps settings and resumes without recall
    // ----------------------------------------------------------------
    supply_ok = 1'b0;
    wait_n(3);
    chk("oe_n dip", 16'h000f, {12'h000, oe_n});
    rd("status dip", 8'h00, 8'h6e, 8'h03);
    count_high(200, hi);
    chk("dip blocked", 16'h0000, hi[15:0]);
    supply_ok = 1'b1;
    wait_n(3);
    chk("oe_n resume", 16'h0001, {12'h000, oe_n});
    rd("config kept", 8'h02, 8'h88, 8'h3c);
    chk("pin out", 16'h0000, {12'h000, pin_out});
    // ----------------------------------------------------------------
    // setpoint table and manual mode
    // ----------------------------------------------------------------
    wr(8'h07, 8'h85, 8'hff);
    wr(8'h02, 8'h88, 8'h31);
    wait_n(3);
    chk("auto setpoint", 16'h00ff, {8'h00, setpoint});
    wr(8'h02, 8'hfe, 8'h12);
    wait_n(3);
    rd("auto wins", 8'h02, 8'hfe, 8'hff);
    wr(8'h02, 8'h88, 8'h30);
    wr(8'h02, 8'hfe, 8'h7f);
    wait_n(3);
    chk("manual setpoint", 16'h007f, {8'h00, setpoint});
    wr(8'h02, 8'hfe, 8'h00);
    wait_n(3);
    chk("setpoint minimum", 16'h0000, {8'h00, setpoint});
    print_verdict();
  end
endmodule
